// ### hdl/pos_pkg.sv
// Constants, types and register map of the PWM offset synchronisation channel
package pos_pkg;

  // Register word byte addresses
  localparam logic [5:0] ADDR_CONTROL    = 6'h00;
  localparam logic [5:0] ADDR_OFFSET_CON = 6'h04;
  localparam logic [5:0] ADDR_LOAD_CON   = 6'h08;
  localparam logic [5:0] ADDR_PHASE      = 6'h0c;
  localparam logic [5:0] ADDR_PERIOD     = 6'h10;
  localparam logic [5:0] ADDR_OFFSET     = 6'h14;
  localparam logic [5:0] ADDR_TIMER      = 6'h18;
  localparam logic [5:0] ADDR_STATUS     = 6'h1c;

  // Field positions
  localparam int CON_EN_BIT     = 7;
  localparam int CON_MODE_LSB   = 2;
  localparam int OFC_OFM_LSB    = 5;
  localparam int OFC_OFO_BIT    = 4;
  localparam int OFC_OFS_LSB    = 0;
  localparam int LDC_ARM_BIT    = 7;
  localparam int STA_STATE_LSB  = 0;
  localparam int STA_DOWN_BIT   = 2;
  localparam int STA_OFO_BIT    = 3;

  // Waveform modes; only center-aligned matters here
  localparam logic [1:0] WAVE_CENTER = 2'h3;

  // Offset modes
  typedef enum logic [1:0] {
    OFM_INDEP   = 2'b00,
    OFM_SYNC    = 2'b01,
    OFM_ONESHOT = 2'b10,
    OFM_CONT    = 2'b11
  } pos_ofm_t;

  // Timer run states
  typedef enum logic [1:0] {
    ST_OFF  = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN  = 2'b10
  } pos_state_t;

  localparam logic [15:0] TIMER_RELOAD = 16'h0001;
  localparam logic [15:0] TIMER_ZERO   = 16'h0000;

  typedef struct packed {
    pos_ofm_t   ofm;
    logic       match_direction_select;
    logic [1:0] ofs;
  } pos_ofcon_t;

  typedef struct packed {
    logic offset_match;
    logic phase_match;
    logic period_match;
  } pos_events_t;

endpackage

// ### hdl/pos_channel.sv
// One PWM channel timer with offset synchronisation to a master channel
//
// Decided for this implementation: the Avalon-MM register port and the address map.
`timescale 1ns/1ns
module pos_channel #(
  parameter int NUM_MASTERS = 4
) (
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        rst_b,
  // Avalon-MM slave
  input  wire logic [5:0]                  address,
  input  wire logic                        read,
  input  wire logic                        write,
  input  wire logic [31:0]                 writedata,
  output      logic [31:0]                 readdata,
  output      logic                        waitrequest,
  // Offset events from master channels, possibly on other module clocks
  input  wire logic [NUM_MASTERS-1:0]      master_offset_event,
  // Own events towards slaves and the waveform stage
  output      pos_pkg::pos_events_t        events,
  output      logic [15:0]                 channel_counter
);

  // Register state
  logic                  en_reg;
  logic [1:0]            wave_mode_reg;
  pos_pkg::pos_ofcon_t   ofcon_reg;
  logic                  ofo_active_reg;
  logic                  load_arm_reg;
  logic [15:0]           phase_value_pair_reg;
  logic [15:0]           period_value_pair_reg;
  logic [15:0]           offset_value_reg;
  logic [15:0]           timer_reg;
  logic                  down_reg;
  pos_pkg::pos_state_t   state_reg;
  logic [31:0]           readdata_reg;
  logic                  wait_reg;
  pos_pkg::pos_events_t  events_reg;

  // Synchroniser and edge detector per master input
  logic [NUM_MASTERS-1:0] sync1_reg;
  logic [NUM_MASTERS-1:0] sync2_reg;
  logic [NUM_MASTERS-1:0] sync3_reg;

  function automatic logic [31:0] pad16(input logic [15:0] v);
    pad16 = {16'h0000, v};
  endfunction

  function automatic logic [31:0] pad8(input logic [7:0] v);
    pad8 = {24'h000000, v};
  endfunction

  // Bus decode
  wire bus_wr   = write && !wait_reg;
  wire bus_rdq  = read && wait_reg;
  wire wr_con   = bus_wr && (address == pos_pkg::ADDR_CONTROL);
  wire wr_ofc   = bus_wr && (address == pos_pkg::ADDR_OFFSET_CON);
  wire wr_ldc   = bus_wr && (address == pos_pkg::ADDR_LOAD_CON);
  wire wr_ph    = bus_wr && (address == pos_pkg::ADDR_PHASE);
  wire wr_pr    = bus_wr && (address == pos_pkg::ADDR_PERIOD);
  wire wr_of    = bus_wr && (address == pos_pkg::ADDR_OFFSET);
  wire wr_tmr   = bus_wr && (address == pos_pkg::ADDR_TIMER);

  // Control fields
  wire       wr_en_bit  = writedata[pos_pkg::CON_EN_BIT];
  wire [1:0] wr_wave    = writedata[pos_pkg::CON_MODE_LSB +: 2];
  wire [1:0] wr_ofm     = writedata[pos_pkg::OFC_OFM_LSB +: 2];
  wire       wr_ofo     = writedata[pos_pkg::OFC_OFO_BIT];
  wire [1:0] wr_ofs     = writedata[pos_pkg::OFC_OFS_LSB +: 2];
  wire       wr_arm     = writedata[pos_pkg::LDC_ARM_BIT];
  wire       center     = (wave_mode_reg == pos_pkg::WAVE_CENTER);
  wire       running    = (state_reg == pos_pkg::ST_RUN);

  // Enable in bit 7, waveform mode in bits 3:2, the rest reads as zero
  wire [7:0] con_rd  = {en_reg, 3'h0, wave_mode_reg, 2'h0};
  wire [7:0] ofc_rd  = {1'b0, ofcon_reg.ofm, ofcon_reg.match_direction_select, 2'h0, ofcon_reg.ofs};
  wire [7:0] ldc_rd  = {load_arm_reg, 7'h00};
  wire [7:0] sta_rd  = {4'h0, ofo_active_reg, down_reg, state_reg};

  logic [31:0] rd_mux;
  always_comb
  begin
    case (address)
      pos_pkg::ADDR_CONTROL:    rd_mux = pad8(con_rd);
      pos_pkg::ADDR_OFFSET_CON: rd_mux = pad8(ofc_rd);
      pos_pkg::ADDR_LOAD_CON:   rd_mux = pad8(ldc_rd);
      pos_pkg::ADDR_PHASE:      rd_mux = pad16(phase_value_pair_reg);
      pos_pkg::ADDR_PERIOD:     rd_mux = pad16(period_value_pair_reg);
      pos_pkg::ADDR_OFFSET:     rd_mux = pad16(offset_value_reg);
      pos_pkg::ADDR_TIMER:      rd_mux = pad16(timer_reg);
      pos_pkg::ADDR_STATUS:     rd_mux = pad8(sta_rd);
      default:                  rd_mux = 32'h00000000;
    endcase
  end

  // Selected master event as a one-cycle pulse in this clock
  wire [NUM_MASTERS-1:0] ev_rise = sync2_reg & ~sync3_reg;
  wire master_ev = ev_rise[ofcon_reg.ofs];

  // Period event: top of count, or bottom of the down slope in center mode
  wire at_top     = (timer_reg == period_value_pair_reg);
  wire period_ev  = running && (center ? (down_reg && timer_reg == pos_pkg::TIMER_ZERO)
                                       : at_top);

  // Own offset match; direction bit only counts in center mode
  wire dir_ok     = !center || (down_reg == ofo_active_reg);
  wire offset_ev  = running && (timer_reg == offset_value_reg) && dir_ok;
  wire phase_ev   = running && (timer_reg == phase_value_pair_reg);

  // Timer and run state
  pos_pkg::pos_state_t state_next;
  logic [15:0]         timer_next;
  logic                down_next;
  always_comb
  begin
    state_next = state_reg;
    timer_next = timer_reg;
    down_next  = down_reg;
    if (!en_reg)
    begin
      state_next = pos_pkg::ST_OFF;
    end
    else
    begin
      case (state_reg)
        pos_pkg::ST_OFF:
        begin
          // Independent starts on enable; slaves arm and wait
          if (ofcon_reg.ofm == pos_pkg::OFM_INDEP)
            state_next = pos_pkg::ST_RUN;
          else
            state_next = pos_pkg::ST_WAIT;
        end
        pos_pkg::ST_WAIT:
        begin
          // Mode switch to independent while waiting releases the hold
          if (master_ev || ofcon_reg.ofm == pos_pkg::OFM_INDEP)
            state_next = pos_pkg::ST_RUN;
        end
        pos_pkg::ST_RUN:
        begin
          if (period_ev)
          begin
            timer_next = pos_pkg::TIMER_ZERO;
            down_next  = 1'b0;
            if (ofcon_reg.ofm == pos_pkg::OFM_ONESHOT)
              state_next = pos_pkg::ST_WAIT;
          end
          else if (master_ev && ofcon_reg.ofm == pos_pkg::OFM_CONT)
          begin
            timer_next = pos_pkg::TIMER_RELOAD;
            down_next  = 1'b0;
          end
          else if (center && at_top && !down_reg)
          begin
            down_next  = 1'b1;
            timer_next = timer_reg - 16'h0001;
          end
          else if (down_reg)
          begin
            timer_next = timer_reg - 16'h0001;
          end
          else
          begin
            // Master events in sync and one-shot runs fall through unused
            timer_next = timer_reg + 16'h0001;
          end
        end
        default:
        begin
          state_next = pos_pkg::ST_OFF;
        end
      endcase
    end
    if (wr_tmr)
      timer_next = writedata[15:0];
  end

  // Direction bit load: free while stopped, on armed period boundary while running
  wire ofo_load  = !running || (load_arm_reg && period_ev);
  wire ofo_next  = ofo_load ? (wr_ofc ? wr_ofo : ofcon_reg.match_direction_select) : ofo_active_reg;
  // A new arm written in the load cycle survives the hardware clear
  wire arm_next  = wr_ldc ? wr_arm : (load_arm_reg && !(running && period_ev));

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end
    else
    begin
      sync1_reg <= master_offset_event;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      en_reg                <= 1'b0;
      wave_mode_reg         <= 2'h0;
      ofcon_reg             <= '{pos_pkg::OFM_INDEP, 1'b0, 2'h0};
      ofo_active_reg        <= 1'b0;
      load_arm_reg          <= 1'b0;
      phase_value_pair_reg  <= 16'h0000;
      period_value_pair_reg <= 16'h0000;
      offset_value_reg      <= 16'h0000;
    end
    else
    begin
      if (wr_con)
      begin
        en_reg        <= wr_en_bit;
        wave_mode_reg <= wr_wave;
      end
      if (wr_ofc)
        ofcon_reg <= '{pos_pkg::pos_ofm_t'(wr_ofm), wr_ofo, wr_ofs};
      if (wr_ph)
        phase_value_pair_reg <= writedata[15:0];
      if (wr_pr)
        period_value_pair_reg <= writedata[15:0];
      if (wr_of)
        offset_value_reg <= writedata[15:0];
      ofo_active_reg <= ofo_next;
      load_arm_reg   <= arm_next;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      state_reg  <= pos_pkg::ST_OFF;
      timer_reg  <= 16'h0000;
      down_reg   <= 1'b0;
      events_reg <= '0;
    end
    else
    begin
      state_reg  <= state_next;
      timer_reg  <= timer_next;
      down_reg   <= down_next;
      events_reg <= '{offset_ev, phase_ev, period_ev};
    end
  end

  // One wait cycle per access; waitrequest idles high
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      wait_reg     <= 1'b1;
      readdata_reg <= 32'h00000000;
    end
    else
    begin
      wait_reg <= !((read || write) && wait_reg);
      if (bus_rdq)
        readdata_reg <= rd_mux;
    end
  end

  assign readdata        = readdata_reg;
  assign waitrequest     = wait_reg;
  assign events          = events_reg;
  assign channel_counter = timer_reg;

endmodule

// ### test/pos_channel_asserts.sv
// Port-level checks for the offset synchronisation channel
`timescale 1ns/1ns
module pos_channel_asserts #(
  parameter int NUM_MASTERS = 4
) (
  // Clock and reset
  input wire logic                   clock,
  input wire logic                   rst_b,
  // Register bus
  input wire logic [5:0]             address,
  input wire logic                   read,
  input wire logic                   write,
  input wire logic [31:0]            writedata,
  input wire logic [31:0]            readdata,
  input wire logic                   waitrequest,
  // Events and timer
  input wire logic [NUM_MASTERS-1:0] master_offset_event,
  input wire pos_pkg::pos_events_t   events,
  input wire logic [15:0]            channel_counter
);
  logic [4:0] shadow_reg;
  logic [4:0] shadow_next;
  wire        wr_ofc = write && !waitrequest && address == pos_pkg::ADDR_OFFSET_CON;
  wire        wr_con = write && !waitrequest && address == pos_pkg::ADDR_CONTROL;
  // Mode, source zero, enable and center as last written, taken at the edge the write lands
  assign shadow_next = {wr_ofc ? writedata[6:5] : shadow_reg[4:3], wr_ofc ? writedata[1:0] == 2'h0 : shadow_reg[2],
                        wr_con ? writedata[7] : shadow_reg[1], wr_con ? writedata[3:2] == 2'h3 : shadow_reg[0]};
  always_ff @(posedge clock)
    shadow_reg <= rst_b ? shadow_next : 5'h00;
  wire [1:0]  mode = shadow_reg[4:3];
  wire        en   = shadow_reg[1];
  wire        plain = en && !shadow_reg[0];
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_ack; (read || write) && waitrequest |=> !waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("bus request not answered");
  property p_short; !waitrequest |=> waitrequest; endproperty
  a_short: assert property (p_short) else $error("bus answer too long");
  property p_prd; events.period_match |=> !events.period_match; endproperty
  a_prd: assert property (p_prd) else $error("period pulse too long");
  property p_ofs; events.offset_match |=> !events.offset_match; endproperty
  a_ofs: assert property (p_ofs) else $error("offset pulse too long");
  property p_clr; events.period_match && plain && mode != 2'h2 |-> channel_counter == 16'h0000 ##1
    channel_counter == 16'h0001; endproperty
  a_clr: assert property (p_clr) else $error("timer not cleared and running");
  property p_stop; events.period_match && plain && mode == 2'h2 |-> channel_counter == 16'h0000 [*2]; endproperty
  a_stop: assert property (p_stop) else $error("one-shot timer not stopped");
  property p_run; plain && mode == 2'h2 && $changed(channel_counter) && channel_counter != 16'h0000 |=>
    channel_counter == $past(channel_counter) + 16'h0001 || channel_counter == 16'h0000; endproperty
  a_run: assert property (p_run) else $error("one-shot count disturbed");
  property p_reload; $rose(master_offset_event[0]) && plain && mode == 2'h3 && shadow_reg[2] &&
    channel_counter != 16'h0000 |-> ##3 (channel_counter == 16'h0001 || events.period_match); endproperty
  a_reload: assert property (p_reload) else $error("timer not reloaded");
  c_stop: cover property (events.period_match && mode == 2'h2);
  c_reload: cover property (mode == 2'h3 && channel_counter == 16'h0001);
  c_ofs: cover property (events.offset_match);
endmodule

// ### test/pos_master_model.sv
// Behavioural master channel raising its offset match pulse
`timescale 1ns/1ns
module pos_master_model #(
  parameter logic [15:0] PERIOD = 16'h0013,
  parameter logic [15:0] OFFSET = 16'h0004
) (
  // Clock and reset, shared with the slave so it is never faster
  input wire logic clock,
  input wire logic rst_b,
  // Offset match toward the slave
  output logic     match_pulse
);
  logic [15:0] count_reg;
  wire  [15:0] count_next = (count_reg == PERIOD) ? 16'h0000 : count_reg + 16'h0001;
  always_ff @(posedge clock)
  begin
    count_reg   <= rst_b ? count_next : 16'h0000;
    match_pulse <= rst_b && count_reg == OFFSET;
  end
endmodule

// ### test/pos_channel_test.sv
// Self-checking bench for the offset synchronisation channel
`timescale 1ns/1ns
module pos_channel_test;
  localparam logic [5:0]  CON = pos_pkg::ADDR_CONTROL;
  localparam logic [5:0]  OFC = pos_pkg::ADDR_OFFSET_CON;
  localparam logic [5:0]  STA = pos_pkg::ADDR_STATUS;
  localparam logic [5:0]  PRD = pos_pkg::ADDR_PERIOD;
  localparam logic [31:0] EN  = 32'h1 << pos_pkg::CON_EN_BIT;
  localparam logic [31:0] RUN = 32'(pos_pkg::ST_RUN);
  localparam logic [31:0] WT  = 32'(pos_pkg::ST_WAIT);
  logic                 clock;
  logic                 rst_b;
  logic [5:0]           address;
  logic                 read;
  logic                 write;
  logic [31:0]          writedata;
  logic [31:0]          readdata;
  logic                 waitrequest;
  logic [3:0]           ev;
  pos_pkg::pos_events_t events;
  logic [15:0]          channel_counter;
  logic [31:0]          q;
  int                   err_count = 0;
  int                   comparisons = 0;
  int                   n;
  int                   m;
  int                   p;
  assign ev[3:2] = 2'h0;
  pos_master_model #(.PERIOD(16'h0013), .OFFSET(16'h0004)) i_m0 (.clock(clock), .rst_b(rst_b), .match_pulse(ev[0]));
  pos_master_model #(.PERIOD(16'h000b), .OFFSET(16'h0002)) i_m1 (.clock(clock), .rst_b(rst_b), .match_pulse(ev[1]));
  pos_channel i_dut (.clock(clock), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .master_offset_event(ev),
    .events(events), .channel_counter(channel_counter));
  function automatic logic [31:0] ofm(input pos_pkg::pos_ofm_t v);
    return 32'(v) << pos_pkg::OFC_OFM_LSB;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    address   <= a;
    writedata <= d;
    write     <= w;
    read      <= !w;
    @(posedge clock);
    while (waitrequest !== 1'b0 && k < 20)
    begin
      @(posedge clock);
      k++;
    end
    chk(32'(k < 20), 32'h1);
    q = readdata;
    write <= 1'b0;
    read  <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] mask, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(q & mask, exp);
  endtask
  task automatic wprd;
    int k;
    k = 0;
    do
    begin
      @(posedge clock);
      k++;
    end
    while (events.period_match !== 1'b1 && k < 300);
    chk(32'(k < 300), 32'h1);
  endtask
  task automatic cnt(input int cycles);
    n = 0;
    m = 0;
    p = 0;
    repeat (cycles)
    begin
      @(posedge clock);
      n += int'(events.period_match === 1'b1);
      p += int'(events.phase_match === 1'b1);
      m += int'(events.offset_match === 1'b1);
    end
  endtask
  // Keeps enable writes clear of a match still inside the synchroniser
  task automatic after_m0;
    @(posedge clock iff ev[0] === 1'b1);
    repeat (4) @(posedge clock);
  endtask
  task automatic conclude;
    $display("Comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    $display("MISMATCH %0t run did not finish", $time);
    err_count++;
    conclude;
  end
  initial
  begin
    rst_b = 1'b0;
    address = 6'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    chk({31'h0, waitrequest}, 32'h1);
    bus(PRD, 1'b1, 32'h9);
    bus(pos_pkg::ADDR_OFFSET, 1'b1, 32'h3);
    bus(CON, 1'b1, EN);
    bus(OFC, 1'b1, 32'h1 << pos_pkg::OFC_OFO_BIT);
    rd(STA, 32'hf, RUN);
    bus(pos_pkg::ADDR_LOAD_CON, 1'b1, 32'h80);
    wprd;
    wprd;
    rd(STA, 32'hf, RUN | 32'h8);
    rd(pos_pkg::ADDR_LOAD_CON, 32'h80, 32'h0);
    rd(6'h20, 32'hffffffff, 32'h0);
    cnt(50);
    chk(32'(n), 32'h5);
    chk(32'(m), 32'h5);
    chk(32'(p), 32'h5);
    bus(CON, 1'b1, 32'h0);
    bus(OFC, 1'b1, ofm(pos_pkg::OFM_SYNC));
    after_m0;
    bus(CON, 1'b1, EN);
    rd(STA, 32'h3, WT);
    after_m0;
    rd(STA, 32'h3, RUN);
    bus(CON, 1'b1, 32'h0);
    bus(pos_pkg::ADDR_TIMER, 1'b1, 32'h0);
    bus(PRD, 1'b1, 32'h1d);
    bus(pos_pkg::ADDR_PHASE, 1'b1, 32'h1);
    bus(OFC, 1'b1, ofm(pos_pkg::OFM_CONT));
    after_m0;
    bus(CON, 1'b1, EN);
    rd(STA, 32'h3, WT);
    repeat (2) @(posedge clock iff ev[0] === 1'b1);
    repeat (3) @(posedge clock);
    chk({16'h0, channel_counter}, 32'h1);
    for (int i = 0; i < 2; i++)
    begin
      bus(CON, 1'b1, 32'h0);
      bus(pos_pkg::ADDR_TIMER, 1'b1, 32'h5);
      bus(PRD, 1'b1, i ? 32'h1d : 32'he);
      bus(OFC, 1'b1, ofm(pos_pkg::OFM_ONESHOT));
      bus(CON, 1'b1, EN);
      wprd;
      cnt(190);
      chk(32'(n), i ? 32'h4 : 32'h9);
    end
    conclude;
  end
endmodule
bind pos_channel pos_channel_asserts #(.NUM_MASTERS(NUM_MASTERS)) i_chk (.clock(clock), .rst_b(rst_b),
  .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .master_offset_event(master_offset_event), .events(events),
  .channel_counter(channel_counter));
